// File: src/padi_fifo.v
// Parameterised valid/ready FIFO for converted words
`timescale 1ns/1ns
module padi_fifo #(
    parameter WIDTH = 13,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             sys_clk,
    input  wire             srst,
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    output wire             outValid,
    input  wire             outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wrPtr_q;
    reg [AW-1:0]    rdPtr_q;
    reg [AW:0]      count_q;
    wire            doWr;
    wire            doRd;

    assign inReady  = (count_q != DEPTH[AW:0]);
    assign outValid = (count_q != {(AW+1){1'b0}});
    assign outData  = mem[rdPtr_q];
    assign doWr     = inValid & inReady;
    assign doRd     = outValid & outReady;

    always @(posedge sys_clk) begin
        if (doWr) begin
            mem[wrPtr_q] <= inData;
        end
    end

    always @(posedge sys_clk) begin
        if (srst) begin
            wrPtr_q <= {AW{1'b0}};
            rdPtr_q <= {AW{1'b0}};
            count_q <= {(AW+1){1'b0}};
        end else begin
            if (doWr) begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (doRd) begin
                rdPtr_q <= rdPtr_q + 1'b1;
            end
            if (doWr & ~doRd) begin
                count_q <= count_q + 1'b1;
            end else if (doRd & ~doWr) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule

// File: src/padi_map.vh
// Constants for the pipelined converter digital output block
// Functional notes
// (R1) One conversion starts per rising clock edge
// (R2) Normal mode with outputs driven
// (R3) Converting, outputs high impedance
// (R4) Nap mode, outputs high impedance
// (R5) Sleep mode, outputs high impedance
// (R6) Controller pulses shutdown over 1 us
// (R7) Twelve-bit word, bit 11 most significant
// (R8) Range flag high on over or under
// (R9) Mode level selects format and stabilizer
// (R10) Result appears five cycles after capture; the pins here update on the sixth edge after capture into rawSync1_q
// (R11) Track while low, hold at rise
// (R12) Six stage results aligned then merged
// (R13) Offset binary codes, twos complement MSB flipped
// (R14) Stabilizer needs hundred cycles to relock
// (R15) Capture word and flag together
`ifndef PADI_MAP_VH
`define PADI_MAP_VH

// ************************************************************
// AHB register offsets
// ************************************************************
`define PADI_CTRL_OFS      8'h00
`define PADI_STAT_OFS      8'h04
`define PADI_DATA_OFS      8'h08
`define PADI_SAMP_OFS      8'h0c

// ************************************************************
// Control fields
// ************************************************************
`define PADI_CTRL_SHUTDOWN_SELECT_BIT 0
`define PADI_CTRL_OEN_BIT  1
`define PADI_CTRL_MODE_LSB 2
`define PADI_CTRL_MODE_MSB 3
`define PADI_CTRL_RST      4'h1

// ************************************************************
// Mode levels
// ************************************************************
`define PADI_MODE_GND      2'h0
`define PADI_MODE_THIRD    2'h1
`define PADI_MODE_TWOTHIRD 2'h2
`define PADI_MODE_VDD      2'h3

// ************************************************************
// Timing
// ************************************************************
`define PADI_LATENCY       3'h5
`define PADI_STAGES        6
`define PADI_RELOCK_CYC    7'h64
`define PADI_CLK_NS        10
`define PADI_SHUTDOWN_SELECT_NS       1000
`define PADI_SHUTDOWN_SELECT_CYC      ((`PADI_SHUTDOWN_SELECT_NS + `PADI_CLK_NS - 1) / `PADI_CLK_NS)

`endif

// File: src/padi_top.v
// Digital side of a 12-bit pipelined converter with AHB-Lite control
`timescale 1ns/1ns
`include "padi_map.vh"
module padi_top (
    input  wire        sys_clk,
    input  wire        srst,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output reg  [31:0] hrdata,
    // Raw quantiser input: one sample per edge, with range sign
    input  wire [11:0] rawCode,
    input  wire        rawOver,
    input  wire        rawUnder,
    // Parallel output pins, enable low while driven
    output reg  [11:0] sampleBits,
    output wire [11:0] sampleBitsOen,
    output reg         rangeExceededFlag,
    output wire        rangeExceededFlagOen,
    // Power state indications
    output wire        napActive,
    output wire        sleepActive,
    output wire        stabilizerOn
);
    // ************************************************************
    // State and declarations
    // ************************************************************
    localparam ST_NORMAL = 4'b0001;
    localparam ST_HIZ    = 4'b0010;
    localparam ST_NAP    = 4'b0100;
    localparam ST_SLEEP  = 4'b1000;

    reg  [3:0]  state_q;
    reg  [3:0]  state_d;
    reg  [3:0]  ctrl_q;
    reg  [11:0] rawSync1_q;
    reg  [11:0] rawSync2_q;
    reg  [1:0]  rngSync1_q;
    reg  [1:0]  rngSync2_q;
    reg  [13:0] pipe_q [0:3];
    reg  [12:0] fmtWord;
    reg  [6:0]  relock_q;
    reg  [7:0]  addrPh_q;
    reg         wrPh_q;
    reg         rdPh_q;
    reg  [15:0] sampleCnt_q;
    reg  [12:0] lastWord_q;
    wire        shdnSel;
    wire        outEnN;
    wire [1:0]  modeSel;
    wire        converting;
    wire        valid;
    wire        fifoInReady;
    wire        fifoOutValid;
    wire [12:0] fifoOutData;
    wire        popFifo;
    wire        addrOk;
    wire        locked;
    wire        ctrlWr;
    wire        stageOver;
    wire        stageUnder;
    wire [11:0] stageCode;
    wire [31:0] ctrlWord;
    wire [31:0] statWord;
    wire [31:0] dataWord;
    wire [31:0] sampWord;
    integer     i;

    // ************************************************************
    // Output format
    // ************************************************************
    // Merge of stage results into one saturated, formatted word
    function [12:0] padi_format;
        input [11:0] code;
        input        over;
        input        under;
        input        twos;
        reg   [11:0] sat;
        begin
            sat = code;
            if (over) begin
                sat = 12'hfff; // R13
            end else if (under) begin
                sat = 12'h000; // R13
            end
            padi_format = {over | under, twos ? {~sat[11], sat[10:0]} : sat}; // R8 R13
        end
    endfunction

    // ************************************************************
    // Control decode
    // ************************************************************
    assign shdnSel      = ctrl_q[`PADI_CTRL_SHUTDOWN_SELECT_BIT];
    assign outEnN       = ctrl_q[`PADI_CTRL_OEN_BIT];
    assign modeSel      = ctrl_q[`PADI_CTRL_MODE_MSB:`PADI_CTRL_MODE_LSB];
    assign stabilizerOn = (modeSel == `PADI_MODE_THIRD) |
                          (modeSel == `PADI_MODE_TWOTHIRD); // R9
    assign napActive    = (state_q == ST_NAP);
    assign sleepActive  = (state_q == ST_SLEEP);
    assign converting   = (state_q == ST_NORMAL) | (state_q == ST_HIZ);
    assign locked       = (relock_q == 7'h00);
    assign valid        = converting & locked;

    // ************************************************************
    // Power state
    // ************************************************************
    // Pins are static levels, so the state simply follows them
    always @* begin
        case ({shdnSel, outEnN})
            2'b00: state_d = ST_NORMAL; // R2
            2'b01: state_d = ST_HIZ; // R3
            2'b10: state_d = ST_NAP; // R4
            2'b11: state_d = ST_SLEEP; // R5
            default: state_d = ST_SLEEP;
        endcase
    end

    // ************************************************************
    // State register
    // ************************************************************
    always @(posedge sys_clk) begin
        if (srst) begin
            state_q <= ST_NORMAL;
        end else begin
            state_q <= state_d;
        end
    end

    // ************************************************************
    // Stabilizer relock
    // ************************************************************
    // Shutdown stops the loop, so recount on leaving it; words are
    // still converted while counting but are kept out of the buffer
    always @(posedge sys_clk) begin
        if (srst) begin
            relock_q <= 7'h00;
        end else if (!converting && stabilizerOn) begin
            relock_q <= `PADI_RELOCK_CYC; // R14
        end else if (relock_q != 7'h00) begin
            relock_q <= relock_q - 7'h01; // R14
        end
    end

    // ************************************************************
    // Input synchroniser
    // ************************************************************
    // Raw code comes from the analog side, so it is synchronised first
    // Not reset: these flops only ever carry pin levels
    always @(posedge sys_clk) begin
        rawSync1_q <= rawCode; // R11
        rawSync2_q <= rawSync1_q;
        rngSync1_q <= {rawOver, rawUnder};
        rngSync2_q <= rngSync1_q;
    end

    // ************************************************************
    // Conversion pipeline
    // ************************************************************
    // Stage results travel together so all six stay aligned; over and
    // under ride separately, as saturation needs to know which end
    always @(posedge sys_clk) begin
        if (srst) begin
            for (i = 0; i < 4; i = i + 1) begin
                pipe_q[i] <= 14'h0000;
            end
        end else if (converting) begin
            pipe_q[0] <= {rngSync2_q, rawSync2_q}; // R1 R12
            for (i = 1; i < 4; i = i + 1) begin
                pipe_q[i] <= pipe_q[i-1]; // R10 R12
            end
        end
    end

    assign stageOver  = pipe_q[3][13];
    assign stageUnder = pipe_q[3][12];
    assign stageCode  = pipe_q[3][11:0];

    always @* begin
        fmtWord = padi_format(stageCode, stageOver, stageUnder, modeSel[1]); // R9 R13
    end

    // ************************************************************
    // Output pins
    // ************************************************************
    // Sixth edge after capture into rawSync1_q updates the pins
    always @(posedge sys_clk) begin
        if (srst) begin
            sampleBits        <= 12'h000;
            rangeExceededFlag <= 1'b0;
        end else if (converting) begin
            sampleBits        <= fmtWord[11:0]; // R7 R10
            rangeExceededFlag <= fmtWord[12]; // R8
        end
    end

    // Enables low only in normal mode; all other states release the pins
    assign sampleBitsOen        = {12{state_q != ST_NORMAL}}; // R2 R3 R4 R5
    assign rangeExceededFlagOen = (state_q != ST_NORMAL);

    // ************************************************************
    // Sample buffer for software readout
    // ************************************************************
    // Only words from a locked converter are pushed
    padi_fifo #(
        .WIDTH (13),
        .DEPTH (8),
        .AW    (3)
    ) u_fifo (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .inValid  (valid),
        .inReady  (fifoInReady),
        .inData   ({rangeExceededFlag, sampleBits}), // R15
        .outValid (fifoOutValid),
        .outReady (popFifo),
        .outData  (fifoOutData)
    );

    // ************************************************************
    // AHB-Lite slave, zero wait states
    // ************************************************************
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign addrOk    = hsel & hready & htrans[1];
    assign popFifo   = rdPh_q & (addrPh_q == `PADI_DATA_OFS);
    assign ctrlWr    = wrPh_q & (addrPh_q == `PADI_CTRL_OFS);

    // ************************************************************
    // Bus phase
    // ************************************************************
    // Address phase is held here for the data phase that follows
    always @(posedge sys_clk) begin
        if (srst) begin
            addrPh_q <= 8'h00;
            wrPh_q   <= 1'b0;
            rdPh_q   <= 1'b0;
        end else if (hready) begin
            addrPh_q <= haddr;
            wrPh_q   <= addrOk & hwrite;
            rdPh_q   <= addrOk & ~hwrite;
        end
    end

    // ************************************************************
    // Control register
    // ************************************************************
    // Only this word is writable; writes land at the end of the data phase
    always @(posedge sys_clk) begin
        if (srst) begin
            ctrl_q <= `PADI_CTRL_RST;
        end else if (ctrlWr) begin
            ctrl_q <= hwdata[3:0];
        end
    end

    // ************************************************************
    // Drop counter and last word
    // ************************************************************
    // Dropped words are counted; a full buffer stalls nothing upstream
    always @(posedge sys_clk) begin
        if (srst) begin
            sampleCnt_q <= 16'h0000;
            lastWord_q  <= 13'h0000;
        end else if (valid) begin
            lastWord_q <= {rangeExceededFlag, sampleBits};
            if (!fifoInReady) begin
                sampleCnt_q <= sampleCnt_q + 16'h0001;
            end
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    // Combinational so the word stands in the data phase with no wait
    assign ctrlWord = {28'h0000000, ctrl_q};
    assign statWord = {24'h000000,
                       locked,
                       stabilizerOn,
                       fifoInReady,
                       fifoOutValid,
                       state_q};
    assign dataWord = {fifoOutValid,
                       18'h00000,
                       fifoOutData};
    assign sampWord = {sampleCnt_q,
                       3'h0,
                       lastWord_q};

    always @* begin
        case (addrPh_q)
            `PADI_CTRL_OFS: hrdata = ctrlWord;
            `PADI_STAT_OFS: hrdata = statWord;
            `PADI_DATA_OFS: hrdata = dataWord;
            `PADI_SAMP_OFS: hrdata = sampWord;
            default:        hrdata = 32'h00000000;
        endcase
    end
endmodule

// File: verif/padi_capture_model.sv
// Capturing logic model on the parallel output pins
`timescale 1ns/1ns
module padi_capture_model (
    input  wire        sys_clk,
    input  wire [11:0] sampleBits,
    input  wire [11:0] sampleBitsOen,
    input  wire        rangeExceededFlag,
    input  wire        rangeExceededFlagOen,
    output reg  [12:0] capWord_q
);
    reg  [12:0] lastPin_q = 13'h0000;
    wire [12:0] drv       = {rangeExceededFlag, sampleBits};
    wire [12:0] oen       = {rangeExceededFlagOen, sampleBitsOen};
    // Released pins show the inverse of the last level, never a held copy
    wire [12:0] pinLevel  = (drv & ~oen) | (~lastPin_q & oen);
    initial capWord_q = 13'h0000;
    always @(posedge sys_clk) begin
        lastPin_q <= pinLevel;
        capWord_q <= pinLevel;
    end
endmodule

// File: verif/padi_top_assertions.sv
// Temporal checks on the converter output pins
`timescale 1ns/1ns
module padi_top_assertions (
    input wire        sys_clk,
    input wire        srst,
    input wire [11:0] rawCode,
    input wire        rawOver,
    input wire        rawUnder,
    input wire [11:0] sampleBits,
    input wire [11:0] sampleBitsOen,
    input wire        rangeExceededFlag,
    input wire        rangeExceededFlagOen,
    input wire        napActive,
    input wire        sleepActive
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);
    // One spare cycle over the 7-edge path keeps mode changes out of reach
    sequence conv8;
        (!napActive && !sleepActive)[*8];
    endsequence
    AST_OEN_PAIR: assert property (sampleBitsOen == {12{rangeExceededFlagOen}})
        else $error("pin enables differ");
    AST_NAP_HIZ: assert property (napActive |-> &sampleBitsOen && rangeExceededFlagOen)
        else $error("nap drives pins");
    AST_SLEEP_HIZ: assert property (sleepActive |->
        &sampleBitsOen && rangeExceededFlagOen && !napActive)
        else $error("sleep drives pins");
    AST_FREEZE: assert property (napActive && $past(napActive) |-> $stable(sampleBits))
        else $error("word moved in nap");
    AST_FLAG_LAT: assert property (conv8 |->
        rangeExceededFlag == ($past(rawOver, 7) || $past(rawUnder, 7)))
        else $error("flag latency wrong");
    AST_SAT_HIGH: assert property (conv8 ##0 $past(rawOver, 7) |->
        sampleBits[10:0] == 11'h7ff)
        else $error("over not saturated");
    AST_SAT_LOW: assert property (conv8 ##0
        ($past(rawUnder, 7) && !$past(rawOver, 7)) |->
        sampleBits[10:0] == 11'h000)
        else $error("under not saturated");
    AST_CODE_LAT: assert property (conv8 ##0
        (!$past(rawOver, 7) && !$past(rawUnder, 7)) |->
        sampleBits[10:0] == $past(rawCode[10:0], 7))
        else $error("word latency wrong");
endmodule
bind padi_top padi_top_assertions i_padi_top_assertions (
    .sys_clk(sys_clk), .srst(srst), .rawCode(rawCode), .rawOver(rawOver),
    .rawUnder(rawUnder), .sampleBits(sampleBits), .sampleBitsOen(sampleBitsOen),
    .rangeExceededFlag(rangeExceededFlag), .rangeExceededFlagOen(rangeExceededFlagOen),
    .napActive(napActive), .sleepActive(sleepActive));

// File: verif/pipelined_adc_digital_interface_test.sv
// Self-checking bench for the converter output block
`timescale 1ns/1ns
`include "padi_map.vh"
module pipelined_adc_digital_interface_test;
    reg         sys_clk  = 1'b0;
    reg         srst     = 1'b1;
    reg  [7:0]  haddr    = 8'h00;
    reg  [1:0]  htrans   = 2'h0;
    reg         hwrite   = 1'b0;
    reg  [31:0] hwdata   = 32'h0;
    reg  [11:0] rawCode  = 12'h000;
    reg         rawOver  = 1'b0;
    reg         rawUnder = 1'b0;
    reg  [31:0] rdCap, rd;
    reg  [12:0] ex;
    wire        hreadyout, hresp, napActive, sleepActive, stabilizerOn;
    wire        rangeExceededFlag, rangeExceededFlagOen;
    wire [31:0] hrdata;
    wire [11:0] sampleBits, sampleBitsOen;
    wire [12:0] capWord_q;
    integer     failures = 0, samples_checked = 0, cycles = 0, m;

    padi_top i_padi_top (.sys_clk(sys_clk), .srst(srst), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .rawCode(rawCode), .rawOver(rawOver), .rawUnder(rawUnder),
        .sampleBits(sampleBits), .sampleBitsOen(sampleBitsOen),
        .rangeExceededFlag(rangeExceededFlag), .rangeExceededFlagOen(rangeExceededFlagOen),
        .napActive(napActive), .sleepActive(sleepActive), .stabilizerOn(stabilizerOn));
    padi_capture_model i_padi_capture_model (.sys_clk(sys_clk), .sampleBits(sampleBits),
        .sampleBitsOen(sampleBitsOen), .rangeExceededFlag(rangeExceededFlag),
        .rangeExceededFlagOen(rangeExceededFlagOen), .capWord_q(capWord_q));

    always #5 sys_clk = ~sys_clk;
    // Read data taken before this edge's updates land
    always @(posedge sys_clk) rdCap <= hrdata;
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures = failures + 1;
            summarize;
        end
    end

    task summarize;
        begin
            $display("failures %0d samples_checked %0d", failures, samples_checked);
            if (failures == 0 && samples_checked > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    task chk(input string n, input [31:0] e, input [31:0] s);
        begin
            samples_checked = samples_checked + 1;
            if (s !== e) begin
                failures = failures + 1;
                $display("[ERR] %s exp %h got %h", n, e, s);
            end
        end
    endtask
    task ahb(input w, input [7:0] a, input [31:0] wd);
        begin
            @(posedge sys_clk);
            haddr  <= a;
            hwrite <= w;
            htrans <= 2'h2;
            @(posedge sys_clk);
            while (hreadyout !== 1'b1) @(posedge sys_clk);
            htrans <= 2'h0;
            hwdata <= wd;
            @(posedge sys_clk);
            while (hreadyout !== 1'b1) @(posedge sys_clk);
            @(negedge sys_clk);
            rd = rdCap;
        end
    endtask
    task rchk(input string n, input [7:0] a, input [31:0] mask, input [31:0] e);
        begin
            ahb(1'b0, a, 32'h0);
            chk(n, e, rd & mask);
        end
    endtask
    task drv(input [11:0] c, input o, input u);
        begin
            @(posedge sys_clk);
            rawCode  <= c;
            rawOver  <= o;
            rawUnder <= u;
            repeat (12) @(posedge sys_clk);
            @(negedge sys_clk);
        end
    endtask

    initial begin
        repeat (8) @(posedge sys_clk);
        srst <= 1'b0;
        rchk("ctrl", `PADI_CTRL_OFS, 32'hf, 32'h1);
        rchk("state", `PADI_STAT_OFS, 32'hf, 32'h4);
        chk("oen", 32'hfff, sampleBitsOen);
        chk("nap", 32'h1, napActive);
        chk("resp", 32'h1, {hresp, hreadyout});
        // Shutdown stays high past 1 us before the stabilizer is used
        repeat (101) @(posedge sys_clk);
        ahb(1'b1, `PADI_CTRL_OFS, 32'h4);
        rchk("lock", `PADI_STAT_OFS, 32'hcf, 32'h41);
        repeat (110) @(posedge sys_clk);
        rchk("lock", `PADI_STAT_OFS, 32'h80, 32'h80);
        for (m = 0; m < 4; m = m + 1) begin
            ahb(1'b1, `PADI_CTRL_OFS, m << 2);
            ex = {2'b00, 11'h123 + m[10:0]};
            drv(ex[11:0], 1'b0, 1'b0);
            ex[11] = m[1];
            chk("stab", (m == 1 || m == 2), stabilizerOn);
            chk("word", ex, sampleBits);
            chk("pins", ex, capWord_q);
            chk("oen", 32'h0, sampleBitsOen);
        end
        drv(12'h456, 1'b1, 1'b0);
        chk("over", 32'h17ff, {rangeExceededFlag, sampleBits});
        drv(12'h456, 1'b0, 1'b1);
        chk("under", 32'h1800, {rangeExceededFlag, sampleBits});
        ahb(1'b1, `PADI_CTRL_OFS, 32'he);
        drv(12'h456, 1'b0, 1'b0);
        rchk("state", `PADI_STAT_OFS, 32'hf, 32'h2);
        chk("oen", 32'h1fff, {rangeExceededFlagOen, sampleBitsOen});
        chk("hiz", 32'hc56, {rangeExceededFlag, sampleBits});
        ahb(1'b1, `PADI_CTRL_OFS, 32'hf);
        rchk("state", `PADI_STAT_OFS, 32'hf, 32'h8);
        chk("sleep", 32'h1, sleepActive);
        chk("oen", 32'h1fff, {rangeExceededFlagOen, sampleBitsOen});
        rchk("fifo", `PADI_STAT_OFS, 32'h30, 32'h10);
        ahb(1'b0, `PADI_SAMP_OFS, 32'h0);
        chk("drops", 32'h1, rd[31:16] != 16'h0);
        for (m = 0; m < 8; m = m + 1)
            rchk("pop", `PADI_DATA_OFS, 32'h80001fff, 32'h80000000);
        rchk("pop", `PADI_DATA_OFS, 32'h80000000, 32'h0);
        rchk("fifo", `PADI_STAT_OFS, 32'h30, 32'h20);
        ahb(1'b1, 8'h10, 32'hffffffff);
        rchk("unmap", 8'h10, 32'hffffffff, 32'h0);
        rchk("ctrl", `PADI_CTRL_OFS, 32'hf, 32'hf);
        summarize;
    end
endmodule
